// file: rtl/timebase_pkg.sv
package timebase_pkg;

  // register map, byte addresses on the serial register port
  localparam logic [7:0] PRESCALER_ADDR  = 8'h43;
  localparam logic [7:0] PRESCALER_RESET = 8'h04;
  localparam int         PRESCALER_W     = 5;

  // internal oscillator time base per system tick, in ns
  localparam int INT_TICK_NS = 4000;
  localparam int CLK_NS      = 50;
  // core clocks per internal 4 us tick, rounded down
  localparam int INT_TICK_CYC = INT_TICK_NS / CLK_NS;
  // external input divided by four times the divider integer
  localparam int EXT_DIV_MUL = 4;

  // timer weight N, in units of 1/10000
  localparam logic [31:0] N_FIXED = 32'h0271_61A8;  // 4098.5, the weight for channel code 110
  // channel code whose weight ignores the rate select
  localparam logic [2:0]  CHAN_FIXED_N = 3'h6;
  // fewest external edges per tick, used when the divider field is zero
  localparam logic [6:0]  EXT_MIN_EDGES = 7'h04;

  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_wr_s;

  typedef struct packed {
    logic [1:0] rate;
    logic [2:0] chan;
  } conv_mode_s;

endpackage : timebase_pkg

// file: rtl/timebase_divider_and_data_format.sv
`timescale 1ns/100ps
`default_nettype none
module timebase_divider_and_data_format (
  input  wire logic                     core_clk,
  input  wire logic                     rst,
  input  wire timebase_pkg::reg_wr_s    reg_wr,
  input  wire logic [7:0]               rd_addr,
  input  wire logic [7:0]               rd_base_adc,
  input  wire logic [7:0]               rd_base_pwr,
  input  wire logic [7:0]               rd_base_acc,
  input  wire logic [11:0]              adc_value,
  input  wire logic [23:0]              power_value,
  input  wire logic [31:0]              acc_value,
  input  wire logic                     external_timebase_input,
  input  wire logic                     use_internal_osc,
  input  wire timebase_pkg::conv_mode_s conv_mode,
  output logic [7:0]                    rd_data,
  output logic                          sys_tick,
  output logic [31:0]                   tick_weight_n
);

  logic [4:0]  prescaler_integer_field_q;
  logic [2:0]  ext_sync_q;
  logic [6:0]  edge_cnt_q;
  logic [7:0]  osc_cnt_q;
  logic        sys_tick_q;
  logic [7:0]  rd_data_q;
  logic [31:0] weight_q;
  logic        ext_rise;
  logic        ext_level_q;
  logic [6:0]  ext_limit;

  // prescaler register; upper bits never stored
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prescaler_integer_field_q <= timebase_pkg::PRESCALER_RESET[4:0];
    end else if (reg_wr.valid && reg_wr.addr == timebase_pkg::PRESCALER_ADDR) begin
      prescaler_integer_field_q <= reg_wr.data[4:0];
    end
  end

  // three-stage sync on the async timebase pin; only the second flop reads the first
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ext_sync_q <= 3'h0;
    end else begin
      ext_sync_q <= {ext_sync_q[1:0], external_timebase_input};
    end
  end

  // settled level moves only once stages two and three agree, so a runt pulse counts once at most
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ext_level_q <= 1'b0;
    end else if (ext_sync_q[1] == ext_sync_q[2]) begin
      ext_level_q <= ext_sync_q[2];
    end
  end
  assign ext_rise  = ext_sync_q[1] & ext_sync_q[2] & ~ext_level_q;
  // divider of zero treated as one to avoid a stuck tick
  assign ext_limit = (prescaler_integer_field_q == '0) ? timebase_pkg::EXT_MIN_EDGES
                   : {prescaler_integer_field_q, 2'h0};

  // tick generation from external edges or the internal 4 us base
  always_ff @(posedge core_clk) begin
    if (rst) begin
      edge_cnt_q <= 7'h00;
      osc_cnt_q  <= 8'h00;
      sys_tick_q <= 1'b0;
    end else if (use_internal_osc) begin
      edge_cnt_q <= 7'h00;
      sys_tick_q <= (osc_cnt_q == 8'(timebase_pkg::INT_TICK_CYC - 1));
      osc_cnt_q  <= (osc_cnt_q == 8'(timebase_pkg::INT_TICK_CYC - 1)) ? 8'h00 : osc_cnt_q + 8'h01;
    end else begin
      osc_cnt_q  <= 8'h00;
      sys_tick_q <= 1'b0;
      if (ext_rise) begin
        if (edge_cnt_q + 7'h01 >= ext_limit) begin
          edge_cnt_q <= 7'h00;
          sys_tick_q <= 1'b1;
        end else begin
          edge_cnt_q <= edge_cnt_q + 7'h01;
        end
      end
    end
  end
  assign sys_tick = sys_tick_q;

  // timer weight N in 1/10000 units, rounded; channel code 110 overrides the rate
  always_ff @(posedge core_clk) begin
    if (rst) begin
      weight_q <= timebase_pkg::N_FIXED;
    end else if (conv_mode.chan == timebase_pkg::CHAN_FIXED_N) begin
      weight_q <= timebase_pkg::N_FIXED;
    end else begin
      unique case ({conv_mode.rate, conv_mode.chan})
        // rate 11
        5'h1B:        weight_q <= 32'h0271_927C;
        5'h1A, 5'h1D: weight_q <= 32'h0271_620A;
        5'h19, 5'h1C: weight_q <= 32'h0271_64CE;
        5'h18:        weight_q <= 32'h0271_8235;
        // rate 10
        5'h13:        weight_q <= 32'h0271_91EB;
        5'h12, 5'h15: weight_q <= 32'h0271_6209;
        5'h11, 5'h14: weight_q <= 32'h0271_64C8;
        5'h10:        weight_q <= 32'h0271_830D;
        // rate 01
        5'h0B:        weight_q <= 32'h0271_8E4D;
        5'h0A, 5'h0D: weight_q <= 32'h0271_6204;
        5'h09, 5'h0C: weight_q <= 32'h0271_649E;
        5'h08:        weight_q <= 32'h0271_7FB4;
        // rate 00
        5'h03:        weight_q <= 32'h0271_7530;
        5'h02, 5'h05: weight_q <= 32'h0271_61D9;
        5'h01, 5'h04: weight_q <= 32'h0271_6335;
        5'h00:        weight_q <= 32'h0271_6F9B;
        // channel 111 has no listed weight; fall back to the fixed one
        default:      weight_q <= timebase_pkg::N_FIXED;
      endcase
    end
  end
  assign tick_weight_n = weight_q;

  // byte read mux: consecutive addresses, most significant first
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_data_q <= 8'h00;
    end else if (rd_addr == timebase_pkg::PRESCALER_ADDR) begin
      rd_data_q <= {3'h0, prescaler_integer_field_q};
    end else if (rd_addr == rd_base_adc) begin
      rd_data_q <= adc_value[11:4];
    end else if (rd_addr == rd_base_adc + 8'h01) begin
      rd_data_q <= {adc_value[3:0], 4'h0};
    end else if (rd_addr == rd_base_pwr) begin
      rd_data_q <= power_value[23:16];
    end else if (rd_addr == rd_base_pwr + 8'h01) begin
      rd_data_q <= power_value[15:8];
    end else if (rd_addr == rd_base_pwr + 8'h02) begin
      rd_data_q <= power_value[7:0];
    end else if (rd_addr == rd_base_acc) begin
      rd_data_q <= acc_value[31:24];
    end else if (rd_addr == rd_base_acc + 8'h01) begin
      rd_data_q <= acc_value[23:16];
    end else if (rd_addr == rd_base_acc + 8'h02) begin
      rd_data_q <= acc_value[15:8];
    end else if (rd_addr == rd_base_acc + 8'h03) begin
      rd_data_q <= acc_value[7:0];
    end else begin
      rd_data_q <= 8'h00;
    end
  end
  assign rd_data = rd_data_q;

  property p_prescaler_reset;
    @(posedge core_clk) $fell(rst) |-> prescaler_integer_field_q == timebase_pkg::PRESCALER_RESET[4:0];
  endproperty
  a_prescaler_reset: assert property (p_prescaler_reset) else $error("prescaler reset wrong");

  property p_adc_low;
    @(posedge core_clk) disable iff (rst)
      (rd_addr == rd_base_adc + 8'h01 && rd_addr != timebase_pkg::PRESCALER_ADDR && rd_base_adc != rd_base_adc + 8'h01)
      |=> rd_data[3:0] == 4'h0;
  endproperty
  a_adc_low: assert property (p_adc_low) else $error("adc low nibble not zero");

  property p_reserved_zero;
    @(posedge core_clk) disable iff (rst)
      rd_addr == timebase_pkg::PRESCALER_ADDR |=> rd_data[7:5] == 3'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero");

  property p_mode_fixed;
    @(posedge core_clk) disable iff (rst)
      conv_mode.chan == timebase_pkg::CHAN_FIXED_N |=> tick_weight_n == timebase_pkg::N_FIXED;
  endproperty
  a_mode_fixed: assert property (p_mode_fixed) else $error("weight for channel 110 wrong");

  // internal base: after a tick, eight more internal cycles must not tick again yet
  sequence s_int_tick;
    use_internal_osc && sys_tick;
  endsequence
  sequence s_int_hold;
    use_internal_osc [*8];
  endsequence
  property p_int_tick;
    @(posedge core_clk) disable iff (rst)
      s_int_tick ##1 s_int_hold |-> !sys_tick;
  endproperty
  a_int_tick: assert property (p_int_tick) else $error("internal tick too soon");

  // a write to the prescaler address lands its low five bits on the next edge
  property p_prescaler_write;
    @(posedge core_clk) disable iff (rst)
      reg_wr.valid && reg_wr.addr == timebase_pkg::PRESCALER_ADDR
      |=> prescaler_integer_field_q == $past(reg_wr.data[4:0]);
  endproperty
  a_prescaler_write: assert property (p_prescaler_write) else $error("prescaler write lost");

  // prescaler readback carries the stored field in its low bits
  property p_prescaler_read;
    @(posedge core_clk) disable iff (rst)
      rd_addr == timebase_pkg::PRESCALER_ADDR |=> rd_data[4:0] == $past(prescaler_integer_field_q);
  endproperty
  a_prescaler_read: assert property (p_prescaler_read) else $error("prescaler readback wrong");

  // adc high byte is bits 11..4 unless the prescaler address overlaps it
  property p_adc_high;
    @(posedge core_clk) disable iff (rst)
      rd_addr == rd_base_adc && rd_addr != timebase_pkg::PRESCALER_ADDR
      |=> rd_data == $past(adc_value[11:4]);
  endproperty
  a_adc_high: assert property (p_adc_high) else $error("adc high byte wrong");

  // ticks are single-cycle pulses in either mode
  property p_tick_single;
    @(posedge core_clk) disable iff (rst)
      sys_tick |=> !sys_tick;
  endproperty
  a_tick_single: assert property (p_tick_single) else $error("tick longer than one cycle");

endmodule : timebase_divider_and_data_format
`default_nettype wire

// file: tb/host_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input  wire logic                  core_clk,
  input  wire logic [7:0]            rd_data,
  output var  timebase_pkg::reg_wr_s reg_wr,
  output var  logic [7:0]            rd_addr
);
  initial begin
    reg_wr  = '0;
    rd_addr = 8'h00;
  end
  // one-cycle write strobe; apart from reset, the prescaler field of the device changes only through this
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_wr <= {1'b1, a, d};
    @(negedge core_clk);
    reg_wr.valid <= 1'b0;
  endtask : wr
  // read data is registered, so look one edge after the address is taken
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    rd_addr <= a;
    @(negedge core_clk);
    d = rd_data;
  endtask : rd
  // reverse-path power is the host's own product of aux code and supply code
  function automatic logic [23:0] rev_power(input logic [11:0] auxiliary_input_code,
                                            input logic [11:0] supply_code);
    return 24'(auxiliary_input_code) * 24'(supply_code);
  endfunction : rev_power
endmodule : host_model
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic                     core_clk = 1'b0;
  logic                     rst      = 1'b1;
  logic                     ext_in   = 1'b0;
  logic                     ext_run  = 1'b0;
  logic                     int_osc  = 1'b0;
  logic                     ext_ph   = 1'b0;
  logic [23:0]              pwr_val  = 24'h123456;
  timebase_pkg::conv_mode_s mode     = '0;
  timebase_pkg::reg_wr_s    reg_wr;
  logic [7:0]               rd_addr;
  logic [7:0]               rd_data;
  logic                     sys_tick;
  logic [31:0]              weight;
  int                       error_cnt = 0;
  int                       samples_checked = 0;
  int                       n;

  always #25 core_clk = ~core_clk;
  // external timebase: one rising edge every four core cycles, slow enough for the sync to settle
  always @(negedge core_clk) begin
    if (ext_run) begin
      ext_ph <= ~ext_ph;
      if (ext_ph) ext_in <= ~ext_in;
    end
  end

  host_model host (.core_clk(core_clk), .rd_data(rd_data), .reg_wr(reg_wr), .rd_addr(rd_addr));
  timebase_divider_and_data_format dut (
    .core_clk(core_clk), .rst(rst), .reg_wr(reg_wr), .rd_addr(rd_addr),
    .rd_base_adc(8'h10), .rd_base_pwr(8'h20), .rd_base_acc(8'h30),
    .adc_value(12'hABC), .power_value(pwr_val), .acc_value(32'h89ABCDEF),
    .external_timebase_input(ext_in), .use_internal_osc(int_osc), .conv_mode(mode),
    .rd_data(rd_data), .sys_tick(sys_tick), .tick_weight_n(weight));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk({24'h0, d}, {24'h0, e});
  endtask : rd_chk
  // cycles between ticks; the first tick after a switch may be irregular
  task automatic gap(output int c);
    int t;
    t = 0;
    c = 0;
    for (int i = 0; i < 600 && t < 3; i++) begin
      @(negedge core_clk);
      if (t == 2) c++;
      if (sys_tick === 1'b1) t++;
    end
  endtask : gap
  task automatic t_regs;
    rd_chk(8'h43, 8'h04);
    chk(weight, 32'h02716F9B);
    host.wr(8'h43, 8'hFF);
    rd_chk(8'h43, 8'h1F);
    host.wr(8'h43, 8'h02);
    rd_chk(8'h43, 8'h02);
  endtask : t_regs
  task automatic t_format;
    rd_chk(8'h10, 8'hAB);
    rd_chk(8'h11, 8'hC0);
    for (int i = 0; i < 3; i++) rd_chk(8'h20 + i[7:0], 8'h12 + 8'h22 * i[7:0]);
    for (int i = 0; i < 4; i++) rd_chk(8'h30 + i[7:0], 8'h89 + 8'h22 * i[7:0]);
    pwr_val <= host.rev_power(12'h123, 12'h100);
    @(negedge core_clk);
    chk({8'h0, pwr_val}, 32'h00012300);
    rd_chk(8'h20, 8'h01);
    rd_chk(8'h21, 8'h23);
    rd_chk(8'h22, 8'h00);
    rd_chk(8'h7F, 8'h00);
  endtask : t_format
  // one conversion-mode setting, weight looked at once it has settled
  task automatic mode_chk(input logic [4:0] m, input logic [31:0] e);
    mode <= m;
    repeat (2) @(negedge core_clk);
    chk(weight, e);
  endtask : mode_chk
  task automatic t_weight;
    for (int r = 0; r < 4; r++) mode_chk({r[1:0], 3'b110}, 32'h027161A8);
    mode_chk(5'b11011, 32'h0271927C);
    mode_chk(5'b10100, 32'h027164C8);
    mode_chk(5'b01101, 32'h02716204);
    mode_chk(5'b00011, 32'h02717530);
  endtask : t_weight
  task automatic t_tick;
    int_osc <= 1'b1;
    gap(n);
    chk(n, 80);
    int_osc <= 1'b0;
    ext_run <= 1'b1;
    gap(n);
    chk(n, 32);
  endtask : t_tick
  // mid-run reset brings the divider back to four: sixteen edges, four cycles apart
  task automatic t_reset;
    rst <= 1'b1;
    repeat (2) @(negedge core_clk);
    rst <= 1'b0;
    rd_chk(8'h43, 8'h04);
    gap(n);
    chk(n, 64);
  endtask : t_reset

  task automatic end_sim;
    $display("checked=%0d errors=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  initial begin
    repeat (8) @(negedge core_clk);
    rst <= 1'b0;
    t_regs();
    t_format();
    t_weight();
    t_tick();
    t_reset();
    end_sim();
  end
  // watchdog well beyond the six hundred or so cycles the tests need
  initial begin
    #(50 * 20000);
    error_cnt++;
    end_sim();
  end
endmodule : testbench
`default_nettype wire
